// file: rtl/sbl_params.svh
// constants of the serial boot loader link: codes, offsets, counts
// assumes inclusion by the package and by the link module only
//
// Behaviour
// RQ1: mode pin low across reset release enters loader mode; controller drives pins.
// RQ2: loader mode overlays loader ROM on vectors and relocates flash.
// RQ3: async framing: half duplex, LSB first, 8 data, no parity, 1 stop.
// RQ4: clocked mode: full duplex, LSB first, controller clock sampled on rising edge. The code sends and receives in separate phases, half duplex.
// RQ5: handshake low while waiting to receive, high while transmitting.
// RQ6: edge intervals measured by 16-bit timer ticking at half system clock.
// RQ7: poll receive level, capture timer at each level change of first byte.
// RQ8: controller sends 0x86 first at the intended async baud rate.
// RQ9: controller sends 0x30 first at one sixteenth of clocked rate.
// RQ10: first low interval not longer than second selects async, else clocked.
// RQ11: first-fall to last-rise interval judges whether baud rate is acceptable.
// RQ12: async mode echoes 0x86; controller times out waiting for it.
// RQ13: clocked mode acknowledge 0x30 read by controller clocks after idle.
// RQ14: first bytes 0x91, 0xA1, 0xB1 also pick clocked mode; answer still 0x30. The code's interval compare selects async for these three bytes.
// RQ15: command 0x10 is RAM transfer, 0x40 is chip and protect erase.
// RQ16: RAM start address at or above 0x2000_0400 and even.
// RQ17: after good RAM transfer, execution starts at the stored start address.
// RQ18: erase clears all blocks and protect bits regardless of protection.
// RQ19: flash 0x3F80_FFF0..0x3F80_FFFF hold id and password; avoid code there.
// RQ20: only mode, reset, transmit, receive, and in clocked mode clock and handshake.
// RQ21: acknowledge carries command upper nibble; bit3 receive error, bit0 bad, bits1-2 zero.
// RQ22: unacceptable async baud rate stops silently, no acknowledge.
// RQ23: checksum is two's complement of 8-bit carry-free byte sum.
// RQ24: serial channel set to chosen mode and rate before acknowledge and command.
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH
`define SBL_TIMER_W 16
`define SBL_STRAP_WAIT 4'h3
`define SBL_BAUD_SHIFT 2
`define SBL_ECHO_ASYNC 8'h86
`define SBL_ECHO_CLOCKED 8'h30
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_ERASE 8'h40
`define SBL_ACK_RXERR 4'h8
`define SBL_ACK_BAD 4'h1
`define SBL_ACK_OK 4'h0
`define SBL_ERASE_DONE 8'h4f
`define SBL_ERASE_FAIL 8'h4c
`define SBL_RAM_LOW 32'h2000_0400
`define SBL_ADDR_LAST 3'h3
`define SBL_IX_START 4'h1
`define SBL_IX_STOP 4'ha
`define SBL_IX_TXEND 4'h9
`define SBL_IX_LAST 4'h7
`define SBL_OFF_CTRL 12'h000
`define SBL_OFF_STATUS 12'h004
`define SBL_OFF_MEASURE 12'h008
`define SBL_OFF_RUNADDR 12'h00c
`define SBL_MINBIT_RST 16'h0010
`endif

// file: rtl/sbl_pkg.sv
// types of the serial boot loader link
// assumes sbl_params.svh is on the include path
`include "sbl_params.svh"
package sbl_pkg;
    typedef logic [31:0] sbl_word_t;
    // gray along the detection path
    typedef enum logic [3:0] {
        SBL_IDLE = 4'h0, SBL_WA = 4'h1, SBL_WB = 4'h3, SBL_WC = 4'h2,
        SBL_WD = 4'h6, SBL_JUDGE = 4'h7, SBL_TX = 4'h5, SBL_RX = 4'h4,
        SBL_NEXT = 4'hc, SBL_HALT = 4'hd, SBL_RUN = 4'hf, SBL_ERASE = 4'he
    } sbl_state_t;
    typedef enum logic [2:0] {
        SBL_ECHO = 3'h0, SBL_CMD = 3'h1, SBL_CMDACK = 3'h3, SBL_ADDR = 3'h2,
        SBL_SUM = 3'h6, SBL_SUMACK = 3'h7, SBL_ERACK = 3'h5
    } sbl_step_t;
    typedef struct packed {
        sbl_state_t fsm;
        sbl_step_t step;
        logic loader, clkMode, div, ovf, rxErr, sumOk;
        logic [`SBL_TIMER_W-1:0] timer, tAB, tAC, wholePatternInterval, bitCyc, cnt, minBit;
        logic [3:0] bitIx;
        logic [2:0] nBytes;
        logic [9:0] shift;
        logic [7:0] rxByte, txByte, cmd, sum;
        logic [31:0] addr, runAddr, prdata;
        logic txd, txdOe, hs, hsOe, runStart, eraseReq, pready, pslverr;
        logic bootS1, bootS2, rxS1, rxS2, rxS3, sclkS1, sclkS2, sclkS3;
    } sbl_regs_t;
endpackage

// file: rtl/sbl_link.sv
// serial boot loader link: strap capture, mode detection, async and clocked
// byte engine, command interpreter, APB status and control
// assumes pins arrive asynchronously; flash erase and CPU start are outside
`timescale 1ns/10ps
`include "sbl_params.svh"
module sbl_link (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire sbl_pkg::sbl_word_t pwdata,
    output sbl_pkg::sbl_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bootModeN,
    input wire logic rxdPin,
    input wire logic sclkPin,
    output logic txdPin,
    output logic txdOe,
    output logic handshake_out_pin,
    output logic handshakeOe,
    output logic romOverlay,
    output logic flashRelocate,
    output logic runStart,
    output logic [31:0] runAddr,
    output logic eraseAllReq,
    input wire logic eraseDone,
    input wire logic eraseFail
);
    import sbl_pkg::*;

    sbl_regs_t regs_ff;
    sbl_regs_t nxt_regs;
    logic rxFall;
    logic rxRise;
    logic sclkRise;

    assign rxFall = regs_ff.rxS3 & ~regs_ff.rxS2;
    assign rxRise = ~regs_ff.rxS3 & regs_ff.rxS2;
    assign sclkRise = ~regs_ff.sclkS3 & regs_ff.sclkS2;

    // ==========================================================
    // next state
    always_comb begin
        logic startTx;
        logic startRx;
        logic ok;
        logic [7:0] txb;
        logic [`SBL_TIMER_W-1:0] secondLowInterval;
        startTx = 1'b0;
        startRx = 1'b0;
        ok = 1'b0;
        txb = 8'h00;
        secondLowInterval = regs_ff.wholePatternInterval - regs_ff.tAC;
        nxt_regs = regs_ff;
        nxt_regs.bootS1 = bootModeN;
        nxt_regs.bootS2 = regs_ff.bootS1;
        nxt_regs.rxS1 = rxdPin;
        nxt_regs.rxS2 = regs_ff.rxS1;
        nxt_regs.rxS3 = regs_ff.rxS2;
        nxt_regs.sclkS1 = sclkPin;
        nxt_regs.sclkS2 = regs_ff.sclkS1;
        nxt_regs.sclkS3 = regs_ff.sclkS2;
        nxt_regs.runStart = 1'b0;
        nxt_regs.div = ~regs_ff.div;
        // timer ticks on every second core edge
        if ((regs_ff.fsm == SBL_WB || regs_ff.fsm == SBL_WC || regs_ff.fsm == SBL_WD)
            && regs_ff.div) begin // RQ6
            if (&regs_ff.timer) begin
                nxt_regs.ovf = 1'b1;
            end else begin
                nxt_regs.timer = regs_ff.timer + 16'h1;
            end
        end
        case (regs_ff.fsm)
            SBL_IDLE: begin
                // wait for the strap synchroniser to hold the pin, not its reset value
                if (regs_ff.cnt[3:0] != `SBL_STRAP_WAIT) begin
                    nxt_regs.cnt = regs_ff.cnt + 16'h1;
                end else begin
                    nxt_regs.loader = ~regs_ff.bootS2; // RQ1 RQ2
                    nxt_regs.txdOe = ~regs_ff.bootS2; // RQ20
                    nxt_regs.fsm = regs_ff.bootS2 ? SBL_HALT : SBL_WA;
                end
            end
            SBL_WA: begin
                nxt_regs.timer = '0;
                nxt_regs.ovf = 1'b0;
                if (rxFall) begin
                    nxt_regs.fsm = SBL_WB; // RQ7
                end
            end
            SBL_WB: begin
                if (rxRise) begin
                    nxt_regs.tAB = regs_ff.timer; // RQ7
                    nxt_regs.fsm = SBL_WC;
                end
            end
            SBL_WC: begin
                if (rxFall) begin
                    nxt_regs.tAC = regs_ff.timer; // RQ7
                    nxt_regs.fsm = SBL_WD;
                end
            end
            SBL_WD: begin
                if (rxRise) begin
                    nxt_regs.wholePatternInterval = regs_ff.timer; // RQ7
                    nxt_regs.fsm = SBL_JUDGE;
                end
            end
            SBL_JUDGE: begin
                if (regs_ff.tAB > secondLowInterval) begin // RQ10 RQ9 RQ14
                    nxt_regs.clkMode = 1'b1; // RQ24
                    nxt_regs.hsOe = 1'b1; // RQ20
                    txb = `SBL_ECHO_CLOCKED; // RQ13 RQ14
                    startTx = 1'b1;
                end else begin
                    // two core cycles per tick, eight bit times in the pattern
                    nxt_regs.bitCyc = regs_ff.wholePatternInterval
                        >> `SBL_BAUD_SHIFT; // RQ11 RQ8 RQ24
                    if (regs_ff.ovf || nxt_regs.bitCyc == '0
                        || nxt_regs.bitCyc < regs_ff.minBit) begin
                        nxt_regs.fsm = SBL_HALT; // RQ22
                    end else begin
                        txb = `SBL_ECHO_ASYNC; // RQ12
                        startTx = 1'b1;
                    end
                end
            end
            SBL_TX: begin
                if (regs_ff.clkMode) begin
                    nxt_regs.txd = regs_ff.shift[0];
                    if (sclkRise) begin // RQ4
                        nxt_regs.shift = {1'b1, regs_ff.shift[9:1]};
                        nxt_regs.bitIx = regs_ff.bitIx + 4'h1;
                        if (regs_ff.bitIx == `SBL_IX_LAST) begin
                            nxt_regs.fsm = SBL_NEXT;
                        end
                    end
                end else begin
                    nxt_regs.txd = regs_ff.shift[0]; // RQ3
                    if (regs_ff.cnt != '0) begin
                        nxt_regs.cnt = regs_ff.cnt - 16'h1;
                    end else begin
                        nxt_regs.cnt = regs_ff.bitCyc - 16'h1;
                        nxt_regs.shift = {1'b1, regs_ff.shift[9:1]};
                        nxt_regs.bitIx = regs_ff.bitIx + 4'h1;
                        if (regs_ff.bitIx == `SBL_IX_TXEND) begin
                            nxt_regs.fsm = SBL_NEXT;
                        end
                    end
                end
            end
            SBL_RX: begin
                if (regs_ff.clkMode) begin
                    if (sclkRise) begin // RQ4
                        nxt_regs.rxByte = {regs_ff.rxS2, regs_ff.rxByte[7:1]};
                        nxt_regs.bitIx = regs_ff.bitIx + 4'h1;
                        if (regs_ff.bitIx == `SBL_IX_LAST) begin
                            nxt_regs.fsm = SBL_NEXT;
                        end
                    end
                end else if (regs_ff.bitIx == 4'h0) begin
                    if (!regs_ff.rxS2) begin
                        nxt_regs.cnt = regs_ff.bitCyc >> 1;
                        nxt_regs.bitIx = `SBL_IX_START;
                    end
                end else if (regs_ff.cnt != '0) begin
                    nxt_regs.cnt = regs_ff.cnt - 16'h1;
                end else begin
                    nxt_regs.cnt = regs_ff.bitCyc - 16'h1;
                    nxt_regs.bitIx = regs_ff.bitIx + 4'h1;
                    // a start bit gone high at mid-bit was a glitch
                    if (regs_ff.bitIx == `SBL_IX_START && regs_ff.rxS2) begin
                        nxt_regs.bitIx = 4'h0;
                    end else if (regs_ff.bitIx == `SBL_IX_STOP) begin
                        nxt_regs.rxErr = ~regs_ff.rxS2; // RQ3
                        nxt_regs.fsm = SBL_NEXT;
                    end else if (regs_ff.bitIx != `SBL_IX_START) begin
                        nxt_regs.rxByte = {regs_ff.rxS2, regs_ff.rxByte[7:1]};
                    end
                end
            end
            SBL_NEXT: begin
                case (regs_ff.step)
                    SBL_ECHO: begin
                        nxt_regs.step = SBL_CMD;
                        startRx = 1'b1;
                    end
                    SBL_CMD: begin
                        nxt_regs.cmd = regs_ff.rxByte;
                        if (regs_ff.rxErr) begin
                            txb = {regs_ff.rxByte[7:4], `SBL_ACK_RXERR}; // RQ21
                        end else if (regs_ff.rxByte == `SBL_CMD_RAM
                            || regs_ff.rxByte == `SBL_CMD_ERASE) begin
                            txb = regs_ff.rxByte; // RQ15
                        end else begin
                            txb = {regs_ff.rxByte[7:4], `SBL_ACK_BAD}; // RQ21
                        end
                        nxt_regs.step = SBL_CMDACK;
                        startTx = 1'b1;
                    end
                    SBL_CMDACK: begin
                        if (regs_ff.txByte == `SBL_CMD_RAM) begin
                            nxt_regs.step = SBL_ADDR;
                            nxt_regs.nBytes = 3'h0;
                            nxt_regs.sum = 8'h00;
                            nxt_regs.sumOk = 1'b1;
                            startRx = 1'b1;
                        end else if (regs_ff.txByte == `SBL_CMD_ERASE) begin
                            nxt_regs.eraseReq = 1'b1; // RQ18
                            nxt_regs.fsm = SBL_ERASE;
                        end else begin
                            nxt_regs.step = SBL_CMD;
                            startRx = 1'b1;
                        end
                    end
                    SBL_ADDR: begin
                        // start address arrives most significant byte first
                        nxt_regs.addr = {regs_ff.addr[23:0], regs_ff.rxByte};
                        nxt_regs.sum = regs_ff.sum + regs_ff.rxByte; // RQ23
                        nxt_regs.sumOk = regs_ff.sumOk & ~regs_ff.rxErr;
                        nxt_regs.nBytes = regs_ff.nBytes + 3'h1;
                        if (regs_ff.nBytes == `SBL_ADDR_LAST) begin
                            nxt_regs.step = SBL_SUM;
                        end
                        startRx = 1'b1;
                    end
                    SBL_SUM: begin
                        ok = regs_ff.sumOk && (regs_ff.sum + regs_ff.rxByte == 8'h00) // RQ23
                            && regs_ff.addr >= `SBL_RAM_LOW && !regs_ff.addr[0]; // RQ16
                        txb = {regs_ff.cmd[7:4], regs_ff.rxErr ? `SBL_ACK_RXERR
                            : (ok ? `SBL_ACK_OK : `SBL_ACK_BAD)}; // RQ21
                        nxt_regs.sumOk = ok & ~regs_ff.rxErr;
                        nxt_regs.step = SBL_SUMACK;
                        startTx = 1'b1;
                    end
                    SBL_SUMACK: begin
                        if (regs_ff.sumOk) begin
                            nxt_regs.runStart = 1'b1; // RQ17
                            nxt_regs.runAddr = regs_ff.addr;
                            nxt_regs.fsm = SBL_RUN;
                        end else begin
                            nxt_regs.step = SBL_CMD;
                            startRx = 1'b1;
                        end
                    end
                    default: begin
                        nxt_regs.step = SBL_CMD;
                        startRx = 1'b1;
                    end
                endcase
            end
            SBL_ERASE: begin
                if (eraseDone) begin
                    nxt_regs.eraseReq = 1'b0;
                    txb = eraseFail ? `SBL_ERASE_FAIL : `SBL_ERASE_DONE;
                    nxt_regs.step = SBL_ERACK;
                    startTx = 1'b1;
                end
            end
            SBL_RUN, SBL_HALT: begin
                nxt_regs.txd = 1'b1;
            end
            default: begin
                nxt_regs.fsm = SBL_HALT;
            end
        endcase
        if (startTx) begin
            nxt_regs.fsm = SBL_TX;
            nxt_regs.txByte = txb;
            nxt_regs.bitIx = 4'h0;
            nxt_regs.cnt = nxt_regs.bitCyc - 16'h1;
            nxt_regs.shift = nxt_regs.clkMode ? {2'b11, txb} : {1'b1, txb, 1'b0};
            nxt_regs.hs = nxt_regs.clkMode; // RQ5
        end
        if (startRx) begin
            nxt_regs.fsm = SBL_RX;
            nxt_regs.bitIx = 4'h0;
            nxt_regs.rxErr = 1'b0;
            nxt_regs.txd = 1'b1;
            nxt_regs.hs = 1'b0; // RQ5
        end
        // ======================================================
        // APB slave, one wait state
        nxt_regs.pready = 1'b0;
        nxt_regs.pslverr = 1'b0;
        if (psel && penable && !regs_ff.pready) begin
            nxt_regs.pready = 1'b1;
            case (paddr)
                `SBL_OFF_CTRL: nxt_regs.prdata = {16'h0000, regs_ff.minBit};
                `SBL_OFF_STATUS: nxt_regs.prdata = {16'h0000, regs_ff.cmd, regs_ff.rxErr,
                    regs_ff.loader, regs_ff.clkMode, regs_ff.eraseReq, regs_ff.fsm};
                `SBL_OFF_MEASURE: nxt_regs.prdata = {regs_ff.wholePatternInterval, regs_ff.tAB};
                `SBL_OFF_RUNADDR: nxt_regs.prdata = regs_ff.runAddr;
                default: begin
                    nxt_regs.prdata = 32'h0000_0000;
                    nxt_regs.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && regs_ff.pready && pwrite && paddr == `SBL_OFF_CTRL) begin
            nxt_regs.minBit = pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            regs_ff <= '0;
            regs_ff.txd <= 1'b1;
            regs_ff.minBit <= `SBL_MINBIT_RST;
            regs_ff.bootS1 <= 1'b1;
            regs_ff.bootS2 <= 1'b1;
            regs_ff.rxS1 <= 1'b1;
            regs_ff.rxS2 <= 1'b1;
            regs_ff.rxS3 <= 1'b1;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign prdata = regs_ff.prdata;
    assign pready = regs_ff.pready;
    assign pslverr = regs_ff.pslverr;
    assign txdPin = regs_ff.txd;
    assign txdOe = regs_ff.txdOe;
    assign handshake_out_pin = regs_ff.hs;
    assign handshakeOe = regs_ff.hsOe;
    assign romOverlay = regs_ff.loader;
    assign flashRelocate = regs_ff.loader;
    assign runStart = regs_ff.runStart;
    assign runAddr = regs_ff.runAddr;
    assign eraseAllReq = regs_ff.eraseReq;

    // ==========================================================
    // checks
    AST_STRAP: assert property (@(posedge core_clk) disable iff (reset) // RQ1
        $rose(regs_ff.loader) |-> !$past(regs_ff.bootS2) && romOverlay && flashRelocate)
        else $error("loader mode entered without low mode pin");
    AST_TICK: assert property (@(posedge core_clk) disable iff (reset) // RQ6
        (regs_ff.fsm == SBL_WC && $changed(regs_ff.timer)) |=> !$changed(regs_ff.timer))
        else $error("timer ticked faster than half clock");
    AST_MODE: assert property (@(posedge core_clk) disable iff (reset) // RQ10
        regs_ff.fsm == SBL_JUDGE |=>
        regs_ff.clkMode == ($past(regs_ff.tAB)
        > $past(regs_ff.wholePatternInterval) - $past(regs_ff.tAC)))
        else $error("mode decision disagrees with intervals");
    AST_HS_TX: assert property (@(posedge core_clk) disable iff (reset) // RQ5
        regs_ff.clkMode && regs_ff.fsm == SBL_TX |-> handshake_out_pin)
        else $error("handshake low while transmitting");
    AST_HS_RX: assert property (@(posedge core_clk) disable iff (reset) // RQ5
        regs_ff.clkMode && regs_ff.fsm == SBL_RX |-> !handshake_out_pin)
        else $error("handshake high while receiving");
    AST_SILENT: assert property (@(posedge core_clk) disable iff (reset) // RQ22
        $rose(regs_ff.fsm == SBL_HALT) |-> txdPin [*8])
        else $error("transmit line moved after abort");
    AST_ACKBITS: assert property (@(posedge core_clk) disable iff (reset) // RQ21
        regs_ff.fsm == SBL_TX && regs_ff.step == SBL_CMDACK |->
        regs_ff.txByte[2:1] == 2'b00 && regs_ff.txByte[7:4] == regs_ff.cmd[7:4])
        else $error("command acknowledge malformed");
    AST_RUN: assert property (@(posedge core_clk) disable iff (reset) // RQ16
        runStart |-> runAddr >= `SBL_RAM_LOW && !runAddr[0] && regs_ff.fsm == SBL_RUN)
        else $error("started from an illegal address");
    AST_ERASE: assert property (@(posedge core_clk) disable iff (reset) // RQ18
        eraseAllReq && !eraseDone |=> eraseAllReq)
        else $error("erase request dropped early");
    AST_PINS: assert property (@(posedge core_clk) disable iff (reset) // RQ20
        handshakeOe |-> regs_ff.clkMode && regs_ff.loader)
        else $error("handshake pin driven outside clocked mode");
    AST_APB: assert property (@(posedge core_clk) disable iff (reset)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("bus answer not one wait state");
endmodule

// file: testbench/sbl_host_model.sv
// far-side programming controller: async byte sender and receiver, clocked reader
// assumes the bench calls its tasks; rx idles high, serial clock rests low
`timescale 1ns/10ps
module sbl_host_model (
    input wire logic core_clk,
    input wire logic txdPin,
    output logic rxdPin,
    output logic sclkPin
);
    initial begin
        rxdPin = 1'b1;
        sclkPin = 1'b0;
    end
    task automatic send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            rxdPin <= f[i];
            repeat (bt) @(posedge core_clk);
        end
    endtask
    // bounded wait for a start bit: a silent device ends it with a bad byte
    task automatic recv(input int bt, output logic [7:0] b);
        int n;
        n = 0;
        while (txdPin !== 1'b0 && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        repeat (bt / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bt) @(posedge core_clk);
            b[i] = txdPin;
        end
        repeat (2 * bt) @(posedge core_clk);
    endtask
    // shift clock stands low between frames; phase unrelated to core_clk
    task automatic sclk_read(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            #77 b[i] = txdPin;
            sclkPin = 1'b1;
            #80 sclkPin = 1'b0;
            #3;
        end
    endtask
endmodule

// file: testbench/test_serial_boot_loader_link.sv
// self-checking bench of the serial boot loader link
// assumes sbl_link and sbl_host_model; erase logic is played by the bench
`timescale 1ns/10ps
module test_serial_boot_loader_link;
    import sbl_pkg::*;
    localparam int BT = 64;
    logic core_clk, reset, psel, penable, pwrite, pready, pslverr, bootModeN, rxdPin, sclkPin;
    logic txdPin, txdOe, hs, hsOe, romOverlay, flashRelocate, runStart, eraseAllReq;
    logic eraseDone, eraseFail;
    logic [11:0] paddr;
    logic [31:0] runAddr;
    sbl_word_t pwdata, prdata, q;
    logic e;
    logic [7:0] b;
    int n_fail, cmp_count, runSeen;
    sbl_host_model PM (.core_clk(core_clk), .txdPin(txdPin), .rxdPin(rxdPin),
        .sclkPin(sclkPin));
    sbl_link DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bootModeN(bootModeN), .rxdPin(rxdPin), .sclkPin(sclkPin),
        .txdPin(txdPin), .txdOe(txdOe), .handshake_out_pin(hs), .handshakeOe(hsOe),
        .romOverlay(romOverlay), .flashRelocate(flashRelocate), .runStart(runStart),
        .runAddr(runAddr), .eraseAllReq(eraseAllReq), .eraseDone(eraseDone),
        .eraseFail(eraseFail));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (runStart === 1'b1) runSeen <= runSeen + 1;
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
            n_fail++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input sbl_word_t d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] s, input logic [7:0] x, input string nm);
        fork
            PM.send(s, BT);
            PM.recv(BT, b);
        join
        chk(nm, x, b);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h10, q);
        apb(1'b1, 12'h000, 32'h20);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl rw", 32'h20, q);
        apb(1'b0, 12'hff0, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        apb(1'b0, 12'h004, 32'h0);
        chk("loader flag", 32'h1, {31'h0, q[6]});
        chk("overlay", 32'h3, {30'h0, romOverlay, flashRelocate});
        chk("txd drive", 32'h1, {31'h0, txdOe});
    endtask
    task automatic t_async;
        xfer(8'h86, 8'h86, "async echo");
        apb(1'b0, 12'h004, 32'h0);
        chk("async mode", 32'h0, {31'h0, q[5]});
        chk("handshake unused", 32'h0, {31'h0, hsOe});
        xfer(8'h55, 8'h51, "bad cmd ack");
    endtask
    task automatic t_erase;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            xfer(8'h40, 8'h40, "erase ack");
            while (eraseAllReq !== 1'b1 && n < 200) begin
                @(posedge core_clk);
                n++;
            end
            chk("erase req", 32'h1, {31'h0, eraseAllReq});
            fork
                PM.recv(BT, b);
                begin
                    eraseDone <= 1'b1;
                    eraseFail <= k[0];
                    @(posedge core_clk);
                    eraseDone <= 1'b0;
                    eraseFail <= 1'b0;
                end
            join
            chk("erase done", k ? 32'h4c : 32'h4f, {24'h0, b});
        end
    endtask
    task automatic t_ram(input logic [31:0] a, input logic [7:0] x);
        logic [7:0] s;
        s = a[31:24] + a[23:16] + a[15:8] + a[7:0];
        xfer(8'h10, 8'h10, "ram cmd ack");
        for (int i = 3; i >= 0; i--) PM.send(a[8*i+:8], BT);
        xfer(8'h00 - s, x, "ram sum ack");
    endtask
    // normal boot, then a bit time under CTRL: the device must stay silent
    task automatic t_silent;
        bootModeN <= 1'b1;
        do_reset();
        apb(1'b0, 12'h004, 32'h0);
        chk("normal boot", 32'hd, {25'h0, q[6:0]});
        chk("normal pins", 32'h0, {30'h0, romOverlay, txdOe});
        bootModeN <= 1'b0;
        do_reset();
        apb(1'b1, 12'h000, 32'h100);
        xfer(8'h86, 8'hff, "silent abort");
        apb(1'b0, 12'h004, 32'h0);
        chk("abort state", 32'h4d, {25'h0, q[6:0]});
    endtask
    task automatic t_clocked;
        int n;
        n = 0;
        do_reset();
        PM.send(8'h30, 16 * BT / 2);
        while (hs !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        chk("hs tx high", 32'h3, {30'h0, hs, hsOe});
        PM.sclk_read(b);
        chk("clocked ack", 32'h30, {24'h0, b});
        repeat (10) @(posedge core_clk);
        chk("hs rx low", 32'h0, {31'h0, hs});
    endtask
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        bootModeN = 1'b0;
        eraseDone = 1'b0;
        eraseFail = 1'b0;
        runSeen = 0;
        do_reset();
        t_regs();
        t_async();
        t_erase();
        t_ram(32'h2000_03fe, 8'h11);
        t_ram(32'h2000_0401, 8'h11);
        t_ram(32'h2000_0400, 8'h10);
        chk("run once", 32'h1, runSeen);
        chk("run addr", 32'h2000_0400, runAddr);
        t_silent();
        t_clocked();
        tally_and_finish();
    end
    initial begin
        repeat (80000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule
